//--- ptm_defines.vh
// constants for the periodic timer: register map, field positions, mode codes
`ifndef PTM_DEFINES_VH
`define PTM_DEFINES_VH
// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define PTM_OFS_CTRL0 8'h00
`define PTM_OFS_CTRL1 8'h04
`define PTM_OFS_COUNT 8'h08
`define PTM_OFS_CMPA 8'h0c
`define PTM_OFS_CMPP 8'h10
`define PTM_OFS_FLAGS 8'h14
// ----------------------------------------------------------------------------
// control 0 fields
// ----------------------------------------------------------------------------
`define PTM_C0_RUN 3
// ----------------------------------------------------------------------------
// control 1 fields
// ----------------------------------------------------------------------------
`define PTM_C1_MODE_HI 7
`define PTM_C1_MODE_LO 6
`define PTM_C1_PIN_HI 5
`define PTM_C1_PIN_LO 4
`define PTM_C1_INIT 3
`define PTM_C1_INV 2
`define PTM_C1_CAPSRC 1
`define PTM_C1_CLRSEL 0
// ----------------------------------------------------------------------------
// flag register fields, write one to clear
// ----------------------------------------------------------------------------
`define PTM_FL_MATCHA 0
`define PTM_FL_MATCHP 1
// ----------------------------------------------------------------------------
// mode and pin-function codes
// ----------------------------------------------------------------------------
`define PTM_MODE_CMP 2'h0
`define PTM_MODE_CAP 2'h1
`define PTM_MODE_PWM 2'h2
`define PTM_MODE_TMR 2'h3
`define PTM_PF_00 2'h0
`define PTM_PF_01 2'h1
`define PTM_PF_10 2'h2
`define PTM_PF_11 2'h3
// ----------------------------------------------------------------------------
// bus answers, reset values and counter maximum
// ----------------------------------------------------------------------------
`define PTM_RESP_OKAY 2'h0
`define PTM_RESP_SLVERR 2'h2
`define PTM_CTRL_RST 8'h00
`define PTM_CNT_MAX 10'h3ff
`endif

//--- ptm_pin_model.sv
// pin-side model: outside levels on the io and clock pins
`timescale 1ns/1ps
module ptm_pin_model (
  // clock
  input wire core_clk,
  // timer side
  input wire timerIoPinOut,
  input wire timerIoPinOe,
  output wire timerIoPinIn,
  output logic timerClockPin
);
  logic ioExt = 1'b0;
  initial timerClockPin = 1'b0;
  // shared pin: the timer's own drive wins; capture mode never drives it, so only outside edges reach capture
  assign timerIoPinIn = timerIoPinOe ? timerIoPinOut : ioExt;
  task drive_io(input logic v);
    @(posedge core_clk);
    ioExt <= v;
  endtask
  task drive_clk(input logic v);
    @(posedge core_clk);
    timerClockPin <= v;
  endtask
endmodule // ptm_pin_model

//--- ptm_timer.v
// periodic timer with compare, pwm, single pulse and capture modes, axi4-lite slave
//
// Functional notes
// - mode field: 00 compare, 11 timer, 10 pwm/pulse, 01 capture.
// - compare, clear-select low: clear on P match or overflow; both flags raised.
// - compare, clear-select high: clear on A match; only A flag raised.
// - compare A value zero: with clear-select high, counter overflows at 3ff, no A flag.
// - compare mode pin changes only on A match or run rising, never on P match.
// - A match drives pin high, low or toggles per pin function; 00 no change.
// - run rising in compare mode loads the pin with initial level.
// - timer mode counts like compare mode but leaves pin undriven.
// - pwm ignores clear-select; P match sets period, A sets duty.
// - pwm period equals P value 1..1023; zero gives 1024 counts.
// - A value at or above period gives 100 percent duty.
// - pwm raises A flag on A match and P flag on P match.
// - pwm: initial level sets polarity, pin function enables/forces, invert reverses.
// - pwm counting continues while pin function forces a fixed level.
// - single pulse is mode 10 with pin function 11; run rising starts pulse.
// - single pulse: active clock-pin edge sets run automatically.
// - single pulse: A match clears run, ends pulse, flags; software clear ends too.
// - single pulse counter zeroes only on run rising; P and clear-select unused.
// - capture source from io pin or clock pin; edge chosen by pin function.
// - active capture edge latches counter into A value and flags; counter runs on.
// - capture mode P match zeroes counter and flags.
// - capture pin function 11 disables capture; counter keeps running.
// - run rising zeroes counter; run falling holds value.
// - compare pin function: 00 none, 01 low, 10 high, 11 toggle.
// - capture pin function: 00 rising, 01 falling, 10 both, 11 disabled.
`timescale 1ns/1ps
`include "ptm_defines.vh"

module ptm_timer #(
  parameter CNT_W = 10,
  parameter TICK_DIV = 4
) (
  // clock and reset
  input wire core_clk,
  input wire nrst,
  // axi4-lite write address
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // axi4-lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // timer pins
  input wire timerIoPinIn,
  input wire timerClockPin,
  output reg timerIoPinOut,
  output reg timerIoPinOe,
  // flags for the interrupt controller
  output wire matchAFlag,
  output wire matchPFlag
);

  // --------------------------------------------------------------------------
  // reset release and pin synchronisers
  // --------------------------------------------------------------------------
  reg [1:0] rstSync_reg;
  wire rstN = rstSync_reg[1];
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst)
      rstSync_reg <= 2'h0;
    else
      rstSync_reg <= {rstSync_reg[0], 1'b1};
  end

  reg [1:0] ioSync_reg;
  reg [1:0] ckSync_reg;
  reg ioLast_reg;
  reg ckLast_reg;
  always @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      ioSync_reg <= 2'h0;
      ckSync_reg <= 2'h0;
      ioLast_reg <= 1'b0;
      ckLast_reg <= 1'b0;
    end else begin
      ioSync_reg <= {ioSync_reg[0], timerIoPinIn};
      ckSync_reg <= {ckSync_reg[0], timerClockPin};
      ioLast_reg <= ioSync_reg[1];
      ckLast_reg <= ckSync_reg[1];
    end
  end

  // --------------------------------------------------------------------------
  // count tick divider
  // --------------------------------------------------------------------------
  reg [15:0] divCnt_reg;
  wire tick = (divCnt_reg == TICK_DIV - 1);
  always @(posedge core_clk or negedge rstN) begin
    if (!rstN)
      divCnt_reg <= 16'h0000;
    else if (tick)
      divCnt_reg <= 16'h0000;
    else
      divCnt_reg <= divCnt_reg + 16'h0001;
  end

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  reg runSw_reg;
  reg [7:0] ctrl1_reg;
  reg [CNT_W-1:0] cmpA_reg;
  reg [CNT_W-1:0] cmpP_reg;
  reg [CNT_W-1:0] count_reg;
  reg flagA_reg;
  reg flagP_reg;
  reg runLast_reg;

  wire [1:0] mode = {ctrl1_reg[`PTM_C1_MODE_HI], ctrl1_reg[`PTM_C1_MODE_LO]};
  wire [1:0] pinFn = {ctrl1_reg[`PTM_C1_PIN_HI], ctrl1_reg[`PTM_C1_PIN_LO]};
  wire initLevel = ctrl1_reg[`PTM_C1_INIT];
  wire outInvert = ctrl1_reg[`PTM_C1_INV];
  wire capSrc = ctrl1_reg[`PTM_C1_CAPSRC];
  wire clrSel = ctrl1_reg[`PTM_C1_CLRSEL];

  wire modeCmp = (mode == `PTM_MODE_CMP) || (mode == `PTM_MODE_TMR);
  wire modePwm = (mode == `PTM_MODE_PWM) && (pinFn != `PTM_PF_11);
  wire modePulse = (mode == `PTM_MODE_PWM) && (pinFn == `PTM_PF_11);
  wire modeCap = (mode == `PTM_MODE_CAP);

  // --------------------------------------------------------------------------
  // axi4-lite slave: one write and one read at a time
  // --------------------------------------------------------------------------
  reg awHeld_reg;
  reg wHeld_reg;
  reg [7:0] awAddr_reg;
  reg [31:0] wData_reg;
  reg [3:0] wStrb_reg;
  assign s_axi_awready = !awHeld_reg && !s_axi_bvalid;
  assign s_axi_wready = !wHeld_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  wire wrGo = awHeld_reg && wHeld_reg;
  wire wrLane0 = wrGo && wStrb_reg[0];
  wire wrLane1 = wrGo && wStrb_reg[1];
  wire wrMapped = (awAddr_reg == `PTM_OFS_CTRL0) || (awAddr_reg == `PTM_OFS_CTRL1) ||
                  (awAddr_reg == `PTM_OFS_COUNT) || (awAddr_reg == `PTM_OFS_CMPA) ||
                  (awAddr_reg == `PTM_OFS_CMPP) || (awAddr_reg == `PTM_OFS_FLAGS);

  always @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      awHeld_reg <= 1'b0;
      wHeld_reg <= 1'b0;
      awAddr_reg <= 8'h00;
      wData_reg <= 32'h00000000;
      wStrb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PTM_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_reg <= 1'b1;
        awAddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_reg <= 1'b1;
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
      end
      if (wrGo) begin
        awHeld_reg <= 1'b0;
        wHeld_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrMapped ? `PTM_RESP_OKAY : `PTM_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  reg [31:0] rdMux;
  reg rdOk;
  always @* begin
    rdMux = 32'h00000000;
    rdOk = 1'b1;
    case (s_axi_araddr)
      `PTM_OFS_CTRL0: rdMux[`PTM_C0_RUN] = runSw_reg;
      `PTM_OFS_CTRL1: rdMux[7:0] = ctrl1_reg;
      `PTM_OFS_COUNT: rdMux[CNT_W-1:0] = count_reg;
      `PTM_OFS_CMPA: rdMux[CNT_W-1:0] = cmpA_reg;
      `PTM_OFS_CMPP: rdMux[CNT_W-1:0] = cmpP_reg;
      `PTM_OFS_FLAGS: rdMux[1:0] = {flagP_reg, flagA_reg};
      default: rdOk = 1'b0;
    endcase
  end

  always @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `PTM_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdMux;
      s_axi_rresp <= rdOk ? `PTM_RESP_OKAY : `PTM_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // match and edge detection
  // --------------------------------------------------------------------------
  wire pZero = (cmpP_reg == {CNT_W{1'b0}});
  wire aZero = (cmpA_reg == {CNT_W{1'b0}});
  wire atMax = (count_reg == {CNT_W{1'b1}});
  // compare against the next count so match and clear happen on the same tick
  wire [CNT_W-1:0] cntInc = count_reg + {{(CNT_W-1){1'b0}}, 1'b1};
  wire counting = runSw_reg && runLast_reg && tick;
  wire hitP = counting && (pZero ? atMax : (cntInc == cmpP_reg));
  wire hitA = counting && !aZero && (cntInc == cmpA_reg);

  wire capSel = capSrc ? ckSync_reg[1] : ioSync_reg[1];
  wire capPrev = capSrc ? ckLast_reg : ioLast_reg;
  wire capRise = capSel && !capPrev;
  wire capFall = !capSel && capPrev;
  reg capHit;
  always @* begin
    case (pinFn)
      `PTM_PF_00: capHit = capRise;
      `PTM_PF_01: capHit = capFall;
      `PTM_PF_10: capHit = capRise || capFall;
      default: capHit = 1'b0;
    endcase
  end
  wire capture = modeCap && runSw_reg && capHit;
  // an active edge on the clock pin is taken as its rising edge
  wire pulseTrig = modePulse && ckSync_reg[1] && !ckLast_reg && !runSw_reg;

  // events per mode
  wire evA = (modeCmp || modePwm || modePulse) && hitA;
  wire evP = ((modeCmp && !clrSel) || modePwm || modeCap) && hitP;
  wire capFlag = capture;

  // --------------------------------------------------------------------------
  // run bit, counter and compare registers
  // --------------------------------------------------------------------------
  wire runSet = (wrLane0 && awAddr_reg == `PTM_OFS_CTRL0) ? wData_reg[`PTM_C0_RUN] : runSw_reg;
  wire runNext = pulseTrig ? 1'b1 : ((modePulse && evA) ? 1'b0 : runSet);
  wire runRise = runSw_reg && !runLast_reg;

  always @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      runSw_reg <= 1'b0;
      runLast_reg <= 1'b0;
      ctrl1_reg <= `PTM_CTRL_RST;
      cmpA_reg <= {CNT_W{1'b0}};
      cmpP_reg <= {CNT_W{1'b0}};
      count_reg <= {CNT_W{1'b0}};
    end else begin
      runSw_reg <= runNext;
      runLast_reg <= runSw_reg;
      if (wrLane0 && awAddr_reg == `PTM_OFS_CTRL1)
        ctrl1_reg <= wData_reg[7:0];
      if (wrGo && awAddr_reg == `PTM_OFS_CMPP) begin
        if (wStrb_reg[0])
          cmpP_reg[7:0] <= wData_reg[7:0];
        if (wStrb_reg[1])
          cmpP_reg[CNT_W-1:8] <= wData_reg[CNT_W-1:8];
      end
      if (capture) begin
        cmpA_reg <= count_reg;
      end else if (wrGo && awAddr_reg == `PTM_OFS_CMPA) begin
        if (wStrb_reg[0])
          cmpA_reg[7:0] <= wData_reg[7:0];
        if (wStrb_reg[1])
          cmpA_reg[CNT_W-1:8] <= wData_reg[CNT_W-1:8];
      end
      if (runRise)
        count_reg <= {CNT_W{1'b0}};
      else if (counting) begin
        if ((modeCmp && !clrSel && hitP) || ((modePwm || modeCap) && hitP))
          count_reg <= {CNT_W{1'b0}};
        else if (modeCmp && clrSel && hitA)
          count_reg <= {CNT_W{1'b0}};
        else if (modePulse && hitA)
          count_reg <= count_reg;
        else
          count_reg <= cntInc;
      end
    end
  end

  // --------------------------------------------------------------------------
  // flags: hardware set wins over write-one clear
  // --------------------------------------------------------------------------
  wire clrFlags = wrLane0 && awAddr_reg == `PTM_OFS_FLAGS;
  always @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      flagA_reg <= 1'b0;
      flagP_reg <= 1'b0;
    end else begin
      if (evA || capFlag)
        flagA_reg <= 1'b1;
      else if (clrFlags && wData_reg[`PTM_FL_MATCHA])
        flagA_reg <= 1'b0;
      if (evP)
        flagP_reg <= 1'b1;
      else if (clrFlags && wData_reg[`PTM_FL_MATCHP])
        flagP_reg <= 1'b0;
    end
  end
  assign matchAFlag = flagA_reg;
  assign matchPFlag = flagP_reg;

  // --------------------------------------------------------------------------
  // output pin
  // --------------------------------------------------------------------------
  reg cmpLevel_reg;
  reg pwmActive_reg;
  reg cmpLevelNext;
  always @* begin
    cmpLevelNext = cmpLevel_reg;
    if (runRise)
      cmpLevelNext = initLevel;
    else if (evA) begin
      case (pinFn)
        `PTM_PF_01: cmpLevelNext = 1'b0;
        `PTM_PF_10: cmpLevelNext = 1'b1;
        `PTM_PF_11: cmpLevelNext = !cmpLevel_reg;
        default: cmpLevelNext = cmpLevel_reg;
      endcase
    end
  end

  // pwm active from period start until duty count; duty >= period stays active
  wire dutyFull = pZero ? 1'b0 : (cmpA_reg >= cmpP_reg);
  reg pwmNext;
  always @* begin
    pwmNext = pwmActive_reg;
    if (runRise || (modePwm && hitP))
      pwmNext = !aZero;
    else if (modePwm && hitA && !dutyFull)
      pwmNext = 1'b0;
  end

  reg pinNext;
  always @* begin
    pinNext = 1'b0;
    if (modeCmp)
      pinNext = cmpLevelNext;
    else if (modePulse)
      pinNext = (runNext ? initLevel : !initLevel) ^ outInvert;
    else if (modePwm) begin
      case (pinFn)
        `PTM_PF_00: pinNext = !initLevel ^ outInvert;
        `PTM_PF_01: pinNext = initLevel ^ outInvert;
        default: pinNext = (pwmNext ? initLevel : !initLevel) ^ outInvert;
      endcase
    end
  end

  always @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      cmpLevel_reg <= 1'b0;
      pwmActive_reg <= 1'b0;
      timerIoPinOut <= 1'b0;
      timerIoPinOe <= 1'b0;
    end else begin
      cmpLevel_reg <= cmpLevelNext;
      pwmActive_reg <= pwmNext;
      timerIoPinOut <= pinNext;
      timerIoPinOe <= (mode == `PTM_MODE_CMP) || (mode == `PTM_MODE_PWM);
    end
  end

endmodule // ptm_timer

//--- ptm_timer_properties.sv
// port-level assertion checker for the periodic timer
`timescale 1ns/1ps
`include "ptm_defines.vh"
module ptm_timer_properties #(
  parameter CNT_W = 10,
  parameter TICK_DIV = 4
) (
  // clock and reset
  input wire core_clk,
  input wire nrst,
  // register bus
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  // pins and flags
  input wire timerIoPinOe,
  input wire matchAFlag,
  input wire matchPFlag
);
  logic [7:0] awAddr_reg, arAddr_reg, ctl1_reg;
  logic [31:0] wData_reg;
  logic [2:0] wrAge_reg, stable_reg;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  function automatic logic mapped(input logic [7:0] a);
    return a[1:0] == 2'h0 && a <= `PTM_OFS_FLAGS;
  endfunction
  // --------------------------------------------------------------------------
  // shadow of the last accepted control 1 write
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      awAddr_reg <= 8'h00;
      arAddr_reg <= 8'h00;
      wData_reg <= 32'h0;
      ctl1_reg <= `PTM_CTRL_RST;
      wrAge_reg <= 3'h0;
      stable_reg <= 3'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) awAddr_reg <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) wData_reg <= s_axi_wdata;
      if (s_axi_arvalid && s_axi_arready) arAddr_reg <= s_axi_araddr;
      if ((s_axi_awvalid && s_axi_awready) || (s_axi_wvalid && s_axi_wready)) wrAge_reg <= 3'h5;
      else if (wrAge_reg != 3'h0) wrAge_reg <= wrAge_reg - 3'h1;
      if (s_axi_bvalid && s_axi_bready && s_axi_bresp == `PTM_RESP_OKAY &&
          awAddr_reg == `PTM_OFS_CTRL1) begin
        ctl1_reg <= wData_reg[7:0];
        stable_reg <= 3'h0;
      end else if (stable_reg != 3'h7) stable_reg <= stable_reg + 3'h1;
    end
  end
  // --------------------------------------------------------------------------
  // properties
  // --------------------------------------------------------------------------
  property p_bHold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_bHold: assert property (p_bHold) else $error("write response dropped early");
  property p_rHold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid; endproperty
  a_rHold: assert property (p_rHold) else $error("read response dropped early");
  property p_rLat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rLat: assert property (p_rLat) else $error("read answer late");
  property p_busy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_busy: assert property (p_busy) else $error("write taken while response pending");
  property p_wResp;
    $rose(s_axi_bvalid) |->
      s_axi_bresp == (mapped(awAddr_reg) ? `PTM_RESP_OKAY : `PTM_RESP_SLVERR);
  endproperty
  a_wResp: assert property (p_wResp) else $error("wrong write response code");
  property p_rResp;
    $rose(s_axi_rvalid) |-> s_axi_rresp == (mapped(arAddr_reg) ? `PTM_RESP_OKAY : `PTM_RESP_SLVERR);
  endproperty
  a_rResp: assert property (p_rResp) else $error("wrong read response code");
  property p_stickyA; $fell(matchAFlag) |-> wrAge_reg != 3'h0; endproperty
  a_stickyA: assert property (p_stickyA) else $error("flag a cleared without a write");
  property p_stickyP; $fell(matchPFlag) |-> wrAge_reg != 3'h0; endproperty
  a_stickyP: assert property (p_stickyP) else $error("flag p cleared without a write");
  property p_tmrOe; stable_reg == 3'h7 && ctl1_reg[7:6] == `PTM_MODE_TMR |-> !timerIoPinOe; endproperty
  a_tmrOe: assert property (p_tmrOe) else $error("pin driven in timer mode");
  property p_capOe; stable_reg == 3'h7 && ctl1_reg[7:6] == `PTM_MODE_CAP |-> !timerIoPinOe; endproperty
  a_capOe: assert property (p_capOe) else $error("pin driven in capture mode");
  property p_noP;
    stable_reg == 3'h7 && ctl1_reg[6] == ctl1_reg[7] && ctl1_reg[0] |-> !$rose(matchPFlag);
  endproperty
  a_noP: assert property (p_noP) else $error("flag p raised with clear on a");
endmodule // ptm_timer_properties

bind ptm_timer ptm_timer_properties #(.CNT_W(CNT_W), .TICK_DIV(TICK_DIV)) ptm_timer_properties_inst (.*);

//--- ptm_timer_tb.sv
// self-checking testbench for the periodic timer
`timescale 1ns/1ps
`include "ptm_defines.vh"
module ptm_timer_tb;
  logic core_clk, nrst;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd0, rd1;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic timerIoPinIn, timerClockPin, timerIoPinOut, timerIoPinOe, matchAFlag, matchPFlag;
  int nErrors = 0, checksDone = 0, hi, ed, i;
  int tP[6] = '{8, 8, 8, 8, 8, 0};
  int tA[6] = '{2, 9, 2, 2, 2, 512};
  int tN[6] = '{80, 80, 80, 80, 80, 1024};
  int tH[6] = '{20, 80, 60, 0, 80, 512};
  logic [7:0] tC[6] = '{8'ha9, 8'ha9, 8'had, 8'h89, 8'h99, 8'ha9};
  // short count clock keeps the run brief
  ptm_timer #(.TICK_DIV(1)) ptm_timer_inst (.*);
  ptm_pin_model ptm_pin_model_inst (.core_clk(core_clk), .timerIoPinOut(timerIoPinOut),
    .timerIoPinOe(timerIoPinOe), .timerIoPinIn(timerIoPinIn), .timerClockPin(timerClockPin));
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // --------------------------------------------------------------------------
  // bus and check tasks
  // --------------------------------------------------------------------------
  task giveVerdict;
    $display("errors %0d checks %0d", nErrors, checksDone);
    if (nErrors == 0 && checksDone > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checksDone++;
    if (g !== e) begin
      nErrors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic b;
    b = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b) begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      b = s_axi_bvalid;
    end
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d);
    logic r;
    r = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!r) begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      r = s_axi_rvalid;
      d = s_axi_rdata;
      rsp = s_axi_rresp;
    end
  endtask
  task rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    rd(a, rd0);
    chk(nm, e, rd0);
  endtask
  task run(input logic on);
    wr(`PTM_OFS_CTRL0, {28'h0, on, 3'h0});
  endtask
  task pchk(input string nm, input logic e, input logic oe);
    @(negedge core_clk);
    chk(nm, e, oe ? timerIoPinOe : timerIoPinOut);
    @(posedge core_clk);
  endtask
  task meas(input int n);
    logic p;
    hi = 0;
    ed = 0;
    p = timerIoPinOut;
    repeat (n) begin
      @(negedge core_clk);
      hi += timerIoPinOut;
      ed += (timerIoPinOut != p);
      p = timerIoPinOut;
    end
    @(posedge core_clk);
  endtask
  task pin(input logic src, input logic v);
    if (src) ptm_pin_model_inst.drive_clk(v);
    else ptm_pin_model_inst.drive_io(v);
  endtask
  // --------------------------------------------------------------------------
  // test sequence
  // --------------------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge core_clk);
    for (i = 0; i < 6; i++) rdc("reset value", 8'(i * 4), 32'h0);
    rd(8'h18, rd0);
    chk("unmapped read", `PTM_RESP_SLVERR, rsp);
    wr(8'h1c, 32'h1);
    wr(`PTM_OFS_CMPA, 32'h5);
    wr(`PTM_OFS_CMPP, 32'ha);
    rdc("compare p", `PTM_OFS_CMPP, 32'ha);
    for (i = 0; i < 4; i++) begin
      wr(`PTM_OFS_FLAGS, 32'h3);
      wr(`PTM_OFS_CTRL1, {24'h0, `PTM_MODE_CMP, 2'(i), 4'h8});
      run(1'b1);
      pchk("initial level", 1'b1, 1'b0);
      meas(40);
      case (i)
        0, 2: chk("held level", 40, hi);
        1: chk("driven low", 1, ed);
        default: chk("toggles", 1, ed >= 3 && ed <= 5);
      endcase
      run(1'b0);
    end
    rdc("both flags", `PTM_OFS_FLAGS, 32'h3);
    wr(`PTM_OFS_FLAGS, 32'h3);
    wr(`PTM_OFS_CMPP, 32'h3);
    wr(`PTM_OFS_CMPA, 32'h8);
    wr(`PTM_OFS_CTRL1, {24'h0, `PTM_MODE_CMP, `PTM_PF_00, 4'h1});
    run(1'b1);
    repeat (40) @(posedge core_clk);
    rd(`PTM_OFS_COUNT, rd0);
    chk("clear on a", 1, rd0 < 8);
    rdc("flag a only", `PTM_OFS_FLAGS, 32'h1);
    run(1'b0);
    wr(`PTM_OFS_FLAGS, 32'h3);
    wr(`PTM_OFS_CMPA, 32'h0);
    wr(`PTM_OFS_CMPP, 32'h0);
    wr(`PTM_OFS_CTRL1, 32'h0);
    run(1'b1);
    repeat (900) @(posedge core_clk);
    rd(`PTM_OFS_COUNT, rd0);
    chk("no early wrap", 1, rd0 > 32'h370);
    repeat (200) @(posedge core_clk);
    rd(`PTM_OFS_COUNT, rd0);
    chk("wrapped", 1, rd0 < 32'h100);
    rd(`PTM_OFS_FLAGS, rd0);
    chk("overflow flags", 2, rd0);
    run(1'b0);
    rd(`PTM_OFS_COUNT, rd1);
    repeat (5) @(posedge core_clk);
    rdc("count held", `PTM_OFS_COUNT, rd1);
    run(1'b1);
    rd(`PTM_OFS_COUNT, rd0);
    chk("count zeroed", 1, rd0 < 8);
    run(1'b0);
    wr(`PTM_OFS_FLAGS, 32'h3);
    wr(`PTM_OFS_CMPA, 32'h5);
    wr(`PTM_OFS_CMPP, 32'ha);
    wr(`PTM_OFS_CTRL1, {24'h0, `PTM_MODE_TMR, `PTM_PF_10, 4'h0});
    run(1'b1);
    repeat (30) @(posedge core_clk);
    pchk("pin released", 1'b0, 1'b1);
    rdc("timer flags", `PTM_OFS_FLAGS, 32'h3);
    run(1'b0);
    for (i = 0; i < 6; i++) begin
      wr(`PTM_OFS_FLAGS, 32'h3);
      wr(`PTM_OFS_CMPP, 32'(tP[i]));
      wr(`PTM_OFS_CMPA, 32'(tA[i]));
      wr(`PTM_OFS_CTRL1, {24'h0, tC[i]});
      run(1'b1);
      repeat (12) @(posedge core_clk);
      meas(tN[i]);
      chk("pwm high", 1, hi >= tH[i] - 2 && hi <= tH[i] + 2);
      if (i == 0) chk("pwm period", 1, ed >= 19 && ed <= 21);
      rdc("pwm flags", `PTM_OFS_FLAGS, (i == 1) ? 32'h2 : 32'h3);
      run(1'b0);
    end
    wr(`PTM_OFS_FLAGS, 32'h3);
    wr(`PTM_OFS_CMPA, 32'h14);
    wr(`PTM_OFS_CTRL1, 32'hb8);
    pin(1'b1, 1'b1);
    repeat (6) @(posedge core_clk);
    rdc("auto start", `PTM_OFS_CTRL0, 32'h8);
    pchk("leading edge", 1'b1, 1'b0);
    pin(1'b1, 1'b0);
    repeat (30) @(posedge core_clk);
    rdc("auto stop", `PTM_OFS_CTRL0, 32'h0);
    pchk("trailing edge", 1'b0, 1'b0);
    rd(`PTM_OFS_FLAGS, rd0);
    chk("pulse flag", 1, rd0[0]);
    rd(`PTM_OFS_COUNT, rd1);
    repeat (5) @(posedge core_clk);
    rdc("count stopped", `PTM_OFS_COUNT, rd1);
    run(1'b1);
    pchk("soft start", 1'b1, 1'b0);
    run(1'b0);
    pchk("soft stop", 1'b0, 1'b0);
    for (i = 0; i < 4; i++) begin
      wr(`PTM_OFS_FLAGS, 32'h3);
      wr(`PTM_OFS_CMPP, (i == 3) ? 32'hc : 32'h0);
      wr(`PTM_OFS_CTRL1, {24'h0, `PTM_MODE_CAP, 2'(i), 2'b00, i[0], 1'b0});
      run(1'b1);
      repeat (20) @(posedge core_clk);
      pin(i[0], 1'b1);
      repeat (6) @(posedge core_clk);
      rd(`PTM_OFS_FLAGS, rd0);
      chk("flag after rise", (i == 0 || i == 2), rd0[0]);
      pin(i[0], 1'b0);
      repeat (6) @(posedge core_clk);
      rd(`PTM_OFS_FLAGS, rd0);
      chk("flag after fall", i != 3, rd0[0]);
      if (i == 3) begin
        chk("p flag", 1, rd0[1]);
        rd(`PTM_OFS_COUNT, rd1);
        chk("count bound", 1, rd1 < 12);
      end else begin
        rd(`PTM_OFS_CMPA, rd1);
        rd(`PTM_OFS_COUNT, rd0);
        chk("captured", 1, rd1 >= 16 && rd1 < rd0);
      end
      run(1'b0);
    end
    giveVerdict;
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    nErrors++;
    giveVerdict;
  end
endmodule // ptm_timer_tb
